//--- hw/swt_regs.vh
`ifndef SWT_REGS_VH
`define SWT_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SWT_ADDR_W 8
`define SWT_OFS_CONTROL 8'h00
`define SWT_OFS_RELOAD 8'h04
`define SWT_OFS_COUNT 8'h08
`define SWT_OFS_IRQ_ENABLE 8'h0C
`define SWT_OFS_INT_STATUS 8'h10
`define SWT_OFS_INT_MASK 8'h14

// ----------------------------------------
// wake_timer_control fields
// ----------------------------------------
`define SWT_CTL_PS_LSB 0
`define SWT_CTL_PS_MSB 2
`define SWT_CTL_RUN_BIT 3
`define SWT_CTL_FLAG_BIT 4

// ----------------------------------------
// extended_irq_enable_1 field
// ----------------------------------------
`define SWT_IEN_WAKE_BIT 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define SWT_RST_PS 3'h0
`define SWT_RST_RELOAD 8'h00
`define SWT_RST_BYTE 8'h00

// ----------------------------------------
// prescale divide ratios, minus one
// ----------------------------------------
`define SWT_DIV_0 11'h000
`define SWT_DIV_1 11'h003
`define SWT_DIV_2 11'h00F
`define SWT_DIV_3 11'h01F
`define SWT_DIV_4 11'h03F
`define SWT_DIV_5 11'h1FF
`define SWT_DIV_6 11'h3FF
`define SWT_DIV_7 11'h7FF

// ----------------------------------------
// ahb encodings
// ----------------------------------------
`define SWT_HTRANS_NONSEQ 2'b10
`define SWT_HTRANS_SEQ 2'b11

`endif

//--- hw/swt_self_wake_timer.v
// Notes on behaviour
// - the counter keeps running whatever low-power state the chip is in.
// - the only count source is the about 10 kHz low-speed rc oscillator.
// - while the counter runs, the oscillator keep-alive request stays asserted.
// - the counter is an 8-bit up-counter with automatic reload.
// - a 3-bit field in control bits 2..0 selects a prescale from 1/1 to 1/2048.
// - software writes an 8-bit reload value that sets the overflow rate.
// - setting the run bit (control bit 3) starts counting.
// - rolling over from 8'hFF sets the overflow flag at control bit 4.
// - every rollover loads the reload value into the counter.
// - overflow requests the interrupt when enable bit 2 of the extended enable is 1; here int_mask_reg bit 0 must be 1 as well.
// - an overflow is a periodic wake-up event and also serves as a general timer.
//
// The implementer's own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "swt_regs.vh"

module swt_self_wake_timer
(
  // clock and reset
  input wire clock_i,
  input wire arst_n_i,
  // ahb-lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire hready_i,
  input wire [31:0] hwdata_i,
  output reg [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  // low-speed oscillator
  input wire low_speed_rc_osc_i,
  output wire osc_keep_alive_o,
  // events
  output reg wake_o,
  output wire irq_o
);

  // ----------------------------------------
  // prescale decode
  // ----------------------------------------
  function [10:0] swt_div_limit;
    input [2:0] code;
    begin
      case (code)
        3'd0: swt_div_limit = `SWT_DIV_0;
        3'd1: swt_div_limit = `SWT_DIV_1;
        3'd2: swt_div_limit = `SWT_DIV_2;
        3'd3: swt_div_limit = `SWT_DIV_3;
        3'd4: swt_div_limit = `SWT_DIV_4;
        3'd5: swt_div_limit = `SWT_DIV_5;
        3'd6: swt_div_limit = `SWT_DIV_6;
        default: swt_div_limit = `SWT_DIV_7;
      endcase
    end
  endfunction

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // only the lowest 256 bytes of the slot hold registers; the rest reads zero
  function swt_in_window;
    input [31:0] addr;
    begin
      swt_in_window = (addr[31:8] == 24'h00_0000);
    end
  endfunction

  // write strobe for one offset, taken from the registered data-phase address
  function swt_wr_hit;
    input wr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      swt_wr_hit = wr && (addr == ofs);
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [2:0] wake_prescale_sel_reg;
  reg wake_timer_run_reg;
  reg wake_timer_overflow_flag_reg;
  reg [7:0] wake_reload_value_reg;
  reg [7:0] count_reg;
  reg [10:0] presc_reg;
  reg wake_timer_irq_enable_reg;
  reg int_status_reg;
  reg int_mask_reg;
  reg osc_meta_reg;
  reg osc_sync_reg;
  reg osc_prev_reg;
  // saturates three edges after reset; ticks are ignored until then
  reg [1:0] osc_warm_reg;
  reg dp_write_reg;
  reg [7:0] dp_addr_reg;

  reg [7:0] count_next;
  reg [10:0] presc_next;
  reg overflow;
  reg [31:0] rdata_next;

  wire addr_phase;
  wire rd_take;
  wire osc_tick;
  wire [7:0] a_addr;
  wire status_read;
  wire wr_ctl;
  wire wr_reload;
  wire wr_ien;
  wire wr_mask;
  wire in_window;
  wire presc_wrap;
  wire count_top;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  // zero wait states: every transfer completes in its first data cycle
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  // hsize is not decoded: only whole-word transfers are expected
  assign addr_phase = hsel_i & hready_i & htrans_i[1];
  assign rd_take = addr_phase & ~hwrite_i;
  assign a_addr = haddr_i[7:0];
  assign in_window = swt_in_window(haddr_i);
  assign status_read = rd_take && (a_addr == `SWT_OFS_INT_STATUS) && in_window;
  // writes land at the end of the data phase, when hwdata stands
  assign wr_ctl = swt_wr_hit(dp_write_reg, dp_addr_reg, `SWT_OFS_CONTROL);
  assign wr_reload = swt_wr_hit(dp_write_reg, dp_addr_reg, `SWT_OFS_RELOAD);
  assign wr_ien = swt_wr_hit(dp_write_reg, dp_addr_reg, `SWT_OFS_IRQ_ENABLE);
  assign wr_mask = swt_wr_hit(dp_write_reg, dp_addr_reg, `SWT_OFS_INT_MASK);

  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dp_write_reg <= 1'b0;
      dp_addr_reg <= `SWT_RST_BYTE;
    end
    else
    begin
      dp_write_reg <= addr_phase & hwrite_i & in_window;
      dp_addr_reg <= a_addr;
    end
  end

  // ----------------------------------------
  // read data, launched in the address phase
  // ----------------------------------------
  always @*
  begin
    rdata_next = 32'h0000_0000;
    // offsets outside the map and addresses outside the window read zero
    if (in_window)
    begin
      case (a_addr)
        `SWT_OFS_CONTROL:
          rdata_next[4:0] = {wake_timer_overflow_flag_reg, wake_timer_run_reg,
                             wake_prescale_sel_reg};
        `SWT_OFS_RELOAD: rdata_next[7:0] = wake_reload_value_reg;
        `SWT_OFS_COUNT: rdata_next[7:0] = count_reg;
        `SWT_OFS_IRQ_ENABLE: rdata_next[`SWT_IEN_WAKE_BIT] = wake_timer_irq_enable_reg;
        `SWT_OFS_INT_STATUS: rdata_next[0] = int_status_reg;
        `SWT_OFS_INT_MASK: rdata_next[0] = int_mask_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  // holds the last read value until the next read address phase
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      hrdata_o <= 32'h0000_0000;
    else if (rd_take)
      hrdata_o <= rdata_next;
  end

  // ----------------------------------------
  // oscillator tick into the system domain
  // ----------------------------------------
  // edge detect works only with the system clock at least twice the oscillator
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      osc_warm_reg <= 2'b00;
    end
    else
    begin
      osc_meta_reg <= low_speed_rc_osc_i;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
      // reset zeros still in the pipeline would fake a rise of a pin that is high
      if (osc_warm_reg != 2'b11)
        osc_warm_reg <= osc_warm_reg + 2'b01;
    end
  end

  assign osc_tick = osc_sync_reg & ~osc_prev_reg & (&osc_warm_reg);

  // ----------------------------------------
  // prescaler and counter
  // ----------------------------------------
  // no sleep input exists: counting never depends on the power state
  // >= rather than == so a smaller ratio written mid-count wraps at once
  assign presc_wrap = (presc_reg >= swt_div_limit(wake_prescale_sel_reg));
  assign count_top = (count_reg == 8'hFF);

  always @*
  begin
    count_next = count_reg;
    presc_next = presc_reg;
    overflow = 1'b0;
    if (!wake_timer_run_reg)
    begin
      presc_next = 11'h000;
      count_next = wake_reload_value_reg;
    end
    else if (osc_tick)
    begin
      if (presc_wrap)
      begin
        presc_next = 11'h000;
        if (count_top)
        begin
          overflow = 1'b1;
          count_next = wake_reload_value_reg;
        end
        else
          count_next = count_reg + 8'h01;
      end
      else
        presc_next = presc_reg + 11'h001;
    end
  end

  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      count_reg <= `SWT_RST_RELOAD;
      presc_reg <= 11'h000;
    end
    else
    begin
      count_reg <= count_next;
      presc_reg <= presc_next;
    end
  end

  // ----------------------------------------
  // wake pulse and oscillator request
  // ----------------------------------------
  // one clock wide and registered, so a power controller may take it as an edge
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wake_o <= 1'b0;
    else
      wake_o <= overflow;
  end

  // the oscillator must stay on for as long as the count runs
  assign osc_keep_alive_o = wake_timer_run_reg;

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wake_prescale_sel_reg <= `SWT_RST_PS;
      wake_timer_run_reg <= 1'b0;
      wake_reload_value_reg <= `SWT_RST_RELOAD;
      wake_timer_irq_enable_reg <= 1'b0;
      int_mask_reg <= 1'b0;
    end
    else
    begin
      // a control write rewrites prescale and run together
      if (wr_ctl)
      begin
        wake_prescale_sel_reg <= hwdata_i[`SWT_CTL_PS_MSB:`SWT_CTL_PS_LSB];
        wake_timer_run_reg <= hwdata_i[`SWT_CTL_RUN_BIT];
      end
      if (wr_reload)
        wake_reload_value_reg <= hwdata_i[7:0];
      if (wr_ien)
        wake_timer_irq_enable_reg <= hwdata_i[`SWT_IEN_WAKE_BIT];
      if (wr_mask)
        int_mask_reg <= hwdata_i[0];
    end
  end

  // ----------------------------------------
  // overflow flag: a new overflow beats a clear in the same cycle
  // ----------------------------------------
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wake_timer_overflow_flag_reg <= 1'b0;
    else if (overflow)
      wake_timer_overflow_flag_reg <= 1'b1;
    else if (wr_ctl && !hwdata_i[`SWT_CTL_FLAG_BIT])
      wake_timer_overflow_flag_reg <= 1'b0;
  end

  // ----------------------------------------
  // interrupt status: read to clear, a same-cycle overflow wins
  // ----------------------------------------
  // cleared in the address phase; the read data already holds the set bit
  always @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      int_status_reg <= 1'b0;
    else if (overflow)
      int_status_reg <= 1'b1;
    else if (status_read)
      int_status_reg <= 1'b0;
  end

  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  assign irq_o = int_status_reg & int_mask_reg & wake_timer_irq_enable_reg;

endmodule // swt_self_wake_timer
`default_nettype wire

//--- bench/swt_self_wake_timer_sva.sv
`timescale 1ns/1ns
`default_nettype none
module swt_chk
(
  // clock, reset, bus
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // timer side
  input wire logic low_speed_rc_osc_i,
  input wire logic osc_keep_alive_o,
  input wire logic wake_o,
  input wire logic irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  wire logic rd_req = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  wire logic wr_req = hsel_i && hready_i && htrans_i[1] && hwrite_i;
  a_bus_okay: assert property (hreadyout_o && !hresp_o) else $error("bus stalled");
  a_wake_spaced: assert property (wake_o |=> !wake_o [*3]) else $error("wake too close");
  a_wake_needs_run: assert property (wake_o |-> $past(osc_keep_alive_o)) else $error("idle wake");
  a_stop_no_wake: assert property (!osc_keep_alive_o [*8] |-> !wake_o) else $error("stopped wake");
  a_osc_only_src: assert property ($stable(low_speed_rc_osc_i) [*8] |-> !wake_o) else $error("no tick");
  a_run_by_write: assert property ($changed(osc_keep_alive_o) |-> $past(wr_req, 2)) else $error("run");
  a_read_hold: assert property (!rd_req |=> $stable(hrdata_o)) else $error("read data moved");
  a_unmapped_zero: assert property (rd_req && haddr_i[31:8] != 24'h0 |=> hrdata_o == 32'h0) else $error("hole");
  cover property (wake_o && irq_o);
  cover property (wake_o && !irq_o);
  cover property (rd_req && haddr_i[8]);
endmodule // swt_chk
bind swt_self_wake_timer swt_chk chk (.clock_i(clock_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
  .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .low_speed_rc_osc_i(low_speed_rc_osc_i), .osc_keep_alive_o(osc_keep_alive_o),
  .wake_o(wake_o), .irq_o(irq_o));
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "swt_regs.vh"
module tb;
  typedef struct packed {logic [2:0] ps; logic [7:0] rld; int per;} swt_row_t;
  localparam logic [31:0] a_ctl = {24'h0, `SWT_OFS_CONTROL};
  localparam logic [31:0] a_rld = {24'h0, `SWT_OFS_RELOAD};
  localparam logic [31:0] a_ien = {24'h0, `SWT_OFS_IRQ_ENABLE};
  localparam logic [31:0] a_sts = {24'h0, `SWT_OFS_INT_STATUS};
  localparam logic [31:0] a_msk = {24'h0, `SWT_OFS_INT_MASK};
  logic clock_i, arst_n_i, hsel_i, hwrite_i, low_speed_rc_osc_i, osc_en, osc_div;
  logic [1:0] htrans_i;
  logic [31:0] haddr_i, hwdata_i, rdat;
  wire logic [31:0] hrdata_o;
  wire logic hreadyout_o, hresp_o, osc_keep_alive_o, wake_o, irq_o;
  int bad_count, samples_checked, ticks, t0, i;
  swt_row_t rows [8] = '{'{3'h0, 8'hF0, 16}, '{3'h1, 8'hFE, 8}, '{3'h2, 8'hFF, 16},
    '{3'h3, 8'hFF, 32}, '{3'h4, 8'hFF, 64}, '{3'h5, 8'hFF, 512}, '{3'h6, 8'hFF, 1024},
    '{3'h7, 8'hFF, 2048}};
  swt_self_wake_timer dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .low_speed_rc_osc_i(low_speed_rc_osc_i),
    .osc_keep_alive_o(osc_keep_alive_o), .wake_o(wake_o), .irq_o(irq_o));
  // ----
  // bus and checking
  // ----
  task automatic bus(input logic w, input logic [31:0] a, d);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= `SWT_HTRANS_NONSEQ;
    hwrite_i <= w;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    rdat = hrdata_o;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wake_wait;
    do @(posedge clock_i); while (wake_o !== 1'b1);
  endtask
  task automatic conclude;
    if (bad_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // oscillator stand-in: 2 clocks high, 2 low, half the fastest rate the sync allows
  always @(posedge clock_i)
    if (osc_en)
    begin
      osc_div <= ~osc_div;
      if (osc_div)
        low_speed_rc_osc_i <= ~low_speed_rc_osc_i;
      if (osc_div && !low_speed_rc_osc_i)
        ticks <= ticks + 1;
    end
  initial
  begin
    #1000000;
    bad_count++;
    conclude();
  end
  initial
  begin
    arst_n_i = 1'b0;
    hsel_i = 1'b0;
    haddr_i = 32'h0;
    htrans_i = 2'h0;
    hwrite_i = 1'b0;
    hwdata_i = 32'h0;
    low_speed_rc_osc_i = 1'b0;
    osc_en = 1'b0;
    osc_div = 1'b0;
    ticks = 0;
    repeat (10) @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
    bus(0, a_ctl, 0);
    chk(rdat, 0);
    bus(1, a_rld, 32'hFFFF_FF5A);
    // a stopped count copies the reload one clock later
    @(posedge clock_i);
    bus(0, {24'h0, `SWT_OFS_COUNT}, 0);
    chk(rdat, 32'h5A);
    bus(0, 32'h0000_0100, 0);
    chk(rdat, 0);
    bus(0, 32'h0000_0018, 0);
    chk(rdat, 0);
    osc_en <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      bus(1, a_ctl, 0);
      bus(1, a_rld, {24'h0, rows[i].rld});
      bus(1, a_ctl, {28'h0, 1'b1, rows[i].ps});
      wake_wait();
      t0 = ticks;
      wake_wait();
      chk(ticks - t0, rows[i].per);
      bus(0, a_ctl, 0);
      chk(rdat, {27'h0, 2'b11, rows[i].ps});
    end
    bus(1, a_ctl, 32'h10);
    bus(0, a_ctl, 0);
    chk(rdat, 32'h10);
    chk(osc_keep_alive_o, 0);
    bus(1, a_ctl, 0);
    bus(0, a_ctl, 0);
    chk(rdat, 0);
    bus(0, a_sts, 0);
    chk(rdat, 1);
    bus(1, a_ien, 32'h4);
    bus(1, a_msk, 1);
    bus(1, a_rld, 32'hFE);
    bus(1, a_ctl, 32'h8);
    wake_wait();
    chk(irq_o, 1);
    bus(1, a_ctl, 0);
    bus(0, a_sts, 0);
    chk(rdat, 1);
    @(posedge clock_i);
    chk(irq_o, 0);
    bus(1, a_ien, 0);
    bus(1, a_ctl, 32'h8);
    wake_wait();
    @(posedge clock_i);
    chk(irq_o, 0);
    arst_n_i <= 1'b0;
    @(posedge clock_i);
    chk({osc_keep_alive_o, wake_o, irq_o}, 0);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
    bus(0, a_ctl, 0);
    chk(rdat, 0);
    conclude();
  end
endmodule // tb
`default_nettype wire
